// ---- pkg/adc_filter_regs.svh ----
`ifndef ADC_FILTER_REGS_SVH
`define ADC_FILTER_REGS_SVH

// status register
`define STATUS_ADDR        8'hd8
`define STATUS_RESET       8'h00
`define STATUS_RDY_BIT     7
`define STATUS_RSVD_BIT    6
`define STATUS_CAL_BIT     5
`define STATUS_NOREF_BIT   4
`define STATUS_ERR_BIT     3
`define STATUS_RSVD_VALUE  1'b0

// converter mode word
`define MODE_RESET         8'h00
`define MODE_NOTCH_BIT     6
`define MODE_ENABLE_BIT    5
`define MODE_CHOPDIS_BIT   3
`define MODE_SEL_LSB       0
`define MODE_OFF           3'h0
`define MODE_IDLE          3'h1
`define MODE_SINGLE        3'h2
`define MODE_CONT          3'h3
`define MODE_CAL_ZERO_INT  3'h4
`define MODE_CAL_FULL_INT  3'h5
`define MODE_CAL_ZERO_SYS  3'h6
`define MODE_CAL_FULL_SYS  3'h7

// decimation word
`define DECIM_RESET        8'h45
`define DECIM_SHIFT        3
`define DECIM_MIN_CHOP     8'h0d
`define DECIM_MIN_NOTCH    8'h44
`define CHOP_DIVIDE        13'h0003

// reference, buffer and channel codes
`define REF_PRIMARY        2'h1
`define BUF_FULL           2'h0
`define CHAN_BURNOUT_A     4'hc
`define CHAN_BURNOUT_B     4'hd

`endif

// ---- pkg/adc_filter_pkg.sv ----
`default_nettype none
package adc_filter_pkg;
	typedef logic [2:0]  mode_t;
	typedef logic [23:0] sample_t;
	typedef enum logic [1:0] {CONV_STOP, CONV_RUN} conv_state_t;
endpackage
`default_nettype wire

// ---- core/sigma_delta_adc_filter_status_ctrl.sv ----
// Contract
// - decimation factor equals decimation word shifted left by three
// - with chopping on, words below 13 act as 13
// - 60 Hz notch applies only when decimation word is at least 68
// - calibration runs at the currently written decimation word
// - missing reference sets flag, clamps results, blocks calibration writes
// - only the primary reference pair is monitored
// - missing-reference flag bit 4, only while enabled, forces all-ones results
// - result-ready bit 7 sets when conversion or calibration completes
// - result-ready clears by software write or mode-select write
// - no data or coefficient update while result-ready is set
// - calibration-done bit 5 sets on calibration end, cleared by mode write
// - error bit 3 flags clamped or saturated result or blocked coefficient write
// - error bit clears on mode-select write
// - burnout current only on two differential pairs with full buffering
// - status bit 6 reads fixed value, writes ignored
// - output every 8 times word ticks, times three with chopping on
// - with chopping on, result averages current and previous filter outputs
// - decimation word resets to 69
// - any mode-select write resets filter; operation restarts only when enabled with single, continuous or calibration mode selected
`include "adc_filter_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module sigma_delta_adc_filter_status_ctrl (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     srst,
	// status register access
	input  wire logic [7:0]               sfr_addr,
	input  wire logic                     sfr_wr,
	input  wire logic                     sfr_rd,
	input  wire logic [7:0]               sfr_wdata,
	output var  logic [7:0]               sfr_rdata,
	// converter mode and decimation word writes
	input  wire logic                     mode_wr,
	input  wire logic [7:0]               mode_wdata,
	input  wire logic                     word_wr,
	input  wire logic [7:0]               word_wdata,
	// configuration levels
	input  wire logic [1:0]               reference_select,
	input  wire logic [1:0]               buffer_select,
	input  wire logic [3:0]               channel_select,
	input  wire logic                     burnout_enable,
	// modulator and filter datapath
	input  wire logic                     mod_tick,
	input  wire adc_filter_pkg::sample_t  filt_data,
	input  wire logic                     filt_sat,
	input  wire logic                     ref_primary_ok,
	// control outputs
	output var  logic [7:0]               converter_mode_reg,
	output var  logic [7:0]               decimation_word,
	output var  logic [10:0]              decim_factor,
	output var  logic                     filter_reset,
	output var  logic                     notch_active,
	output var  logic                     burnout_active,
	// results
	output var  logic [7:0]               adc_status_flags,
	output var  adc_filter_pkg::sample_t  result_data,
	output var  adc_filter_pkg::sample_t  offset_coeff,
	output var  adc_filter_pkg::sample_t  gain_coeff
);
	import adc_filter_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [7:0] eff_word(input logic [7:0] w, input logic chop_on);
		eff_word = (chop_on && w < `DECIM_MIN_CHOP) ? `DECIM_MIN_CHOP : w;
	endfunction

	function automatic logic is_cal(input mode_t m);
		is_cal = m[2];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state

	conv_state_t state_reg, state_next;
	logic [12:0] tick_cnt_reg, tick_cnt_next;
	logic        prev_valid_reg, prev_valid_next;
	sample_t     prev_reg, prev_next;
	logic [7:0]  mode_reg_next, word_next, stat_next, rdata_next;
	logic [10:0] factor_next;
	logic        freset_next, notch_next, burn_next;
	sample_t     result_next, offs_next, gain_next;

	logic        chop_on, enabled, ref_missing, done, take;
	logic [7:0]  word_eff;
	logic [12:0] target;
	logic [24:0] sum;
	sample_t     avg, stored;
	mode_t       mode_cur;

	always_comb begin
		mode_cur    = converter_mode_reg[`MODE_SEL_LSB +: 3];
		chop_on     = !converter_mode_reg[`MODE_CHOPDIS_BIT];
		enabled     = converter_mode_reg[`MODE_ENABLE_BIT];
		word_eff    = eff_word(decimation_word, chop_on);
		target      = {2'h0, word_eff, 3'h0};
		if (chop_on) begin
			target = 13'(target * `CHOP_DIVIDE);
		end
		ref_missing = enabled && (reference_select == `REF_PRIMARY) && !ref_primary_ok;
		sum         = {1'b0, filt_data} + {1'b0, prev_reg};
		avg         = sum[24:1];
	end

	////////////////////////////////////////////////////////////////////////
	// conversion sequencing

	always_comb begin
		state_next      = state_reg;
		tick_cnt_next   = tick_cnt_reg;
		prev_valid_next = prev_valid_reg;
		prev_next       = prev_reg;
		freset_next     = 1'b0;
		done            = 1'b0;
		unique case (state_reg)
			CONV_STOP: begin
				tick_cnt_next = 13'h0000;
			end
			CONV_RUN: begin
				if (mod_tick) begin
					if (tick_cnt_reg + 13'h0001 >= target) begin
						tick_cnt_next = 13'h0000;
						prev_next     = filt_data;
						if (chop_on && !prev_valid_reg) begin
							prev_valid_next = 1'b1;
						end else begin
							done = 1'b1;
						end
					end else begin
						tick_cnt_next = tick_cnt_reg + 13'h0001;
					end
				end
			end
		endcase
		if (done && mode_cur != `MODE_CONT) begin
			state_next = CONV_STOP;
		end
		if (mode_wr) begin
			freset_next     = 1'b1;
			tick_cnt_next   = 13'h0000;
			prev_valid_next = 1'b0;
			state_next      = (mode_wdata[`MODE_ENABLE_BIT] &&
				mode_wdata[`MODE_SEL_LSB +: 3] >= `MODE_SINGLE) ? CONV_RUN : CONV_STOP;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg      <= CONV_STOP;
			tick_cnt_reg   <= 13'h0000;
			prev_valid_reg <= 1'b0;
			prev_reg       <= 24'h000000;
			filter_reset   <= 1'b1;
		end else begin
			state_reg      <= state_next;
			tick_cnt_reg   <= tick_cnt_next;
			prev_valid_reg <= prev_valid_next;
			prev_reg       <= prev_next;
			filter_reset   <= freset_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// results, status flags and configuration

	always_comb begin
		mode_reg_next = converter_mode_reg;
		word_next     = decimation_word;
		stat_next     = adc_status_flags;
		result_next   = result_data;
		offs_next     = offset_coeff;
		gain_next     = gain_coeff;
		stored        = chop_on ? avg : filt_data;
		take          = done && !adc_status_flags[`STATUS_RDY_BIT] && !mode_wr;

		if (word_wr) begin
			word_next = word_wdata;
		end
		if (sfr_wr && sfr_addr == `STATUS_ADDR && !sfr_wdata[`STATUS_RDY_BIT]) begin
			stat_next[`STATUS_RDY_BIT] = 1'b0;
		end
		if (mode_wr) begin
			mode_reg_next = mode_wdata;
			stat_next[`STATUS_RDY_BIT] = 1'b0;
			stat_next[`STATUS_CAL_BIT] = 1'b0;
			stat_next[`STATUS_ERR_BIT] = 1'b0;
		end
		if (take) begin
			stat_next[`STATUS_RDY_BIT] = 1'b1;
			if (is_cal(mode_cur)) begin
				stat_next[`STATUS_CAL_BIT] = 1'b1;
				if (ref_missing || filt_sat) begin
					stat_next[`STATUS_ERR_BIT] = 1'b1;
				end else if (!mode_cur[0]) begin
					offs_next = stored;
				end else begin
					gain_next = stored;
				end
			end else begin
				result_next = ref_missing ? 24'hffffff : stored;
				if (ref_missing || filt_sat) begin
					stat_next[`STATUS_ERR_BIT] = 1'b1;
				end
			end
			if (mode_cur != `MODE_CONT) begin
				mode_reg_next[`MODE_SEL_LSB +: 3] = `MODE_OFF;
			end
		end
		stat_next[`STATUS_NOREF_BIT] = ref_missing;
		stat_next[`STATUS_RSVD_BIT]  = `STATUS_RSVD_VALUE;
		stat_next[2:0]               = 3'h0;

		factor_next = {word_eff, 3'h0};
		notch_next  = converter_mode_reg[`MODE_NOTCH_BIT] && decimation_word >= `DECIM_MIN_NOTCH;
		burn_next   = burnout_enable && (buffer_select == `BUF_FULL) &&
			(channel_select == `CHAN_BURNOUT_A || channel_select == `CHAN_BURNOUT_B);

		rdata_next = sfr_rdata;
		if (sfr_rd) begin
			rdata_next = (sfr_addr == `STATUS_ADDR) ? adc_status_flags : 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			converter_mode_reg <= `MODE_RESET;
			decimation_word    <= `DECIM_RESET;
			adc_status_flags   <= `STATUS_RESET;
			result_data        <= 24'h000000;
			offset_coeff       <= 24'h000000;
			gain_coeff         <= 24'h000000;
			decim_factor       <= 11'h000;
			notch_active       <= 1'b0;
			burnout_active     <= 1'b0;
			sfr_rdata          <= 8'h00;
		end else begin
			converter_mode_reg <= mode_reg_next;
			decimation_word    <= word_next;
			adc_status_flags   <= stat_next;
			result_data        <= result_next;
			offset_coeff       <= offs_next;
			gain_coeff         <= gain_next;
			decim_factor       <= factor_next;
			notch_active       <= notch_next;
			burnout_active     <= burn_next;
			sfr_rdata          <= rdata_next;
		end
	end

endmodule

`default_nettype wire

// ---- verification/adc_filter_monitor.sv ----
`include "adc_filter_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module adc_filter_monitor (
	// clock and reset
	input wire logic                    clk,
	input wire logic                    srst,
	// stimulus side
	input wire logic                    mode_wr,
	input wire logic [1:0]              reference_select,
	input wire logic [1:0]              buffer_select,
	input wire logic [3:0]              channel_select,
	input wire logic                    burnout_enable,
	input wire logic                    ref_primary_ok,
	// design outputs
	input wire logic [7:0]              converter_mode_reg,
	input wire logic [7:0]              decimation_word,
	input wire logic [10:0]             decim_factor,
	input wire logic                    filter_reset,
	input wire logic                    notch_active,
	input wire logic                    burnout_active,
	input wire logic [7:0]              adc_status_flags,
	input wire adc_filter_pkg::sample_t result_data,
	input wire adc_filter_pkg::sample_t offset_coeff,
	input wire adc_filter_pkg::sample_t gain_coeff
);
	import adc_filter_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	logic [1:0]  up_reg;
	logic [15:0] p1_reg;
	logic [15:0] p2_reg;
	logic [7:0]  s;
	logic [7:0]  m;
	logic [7:0]  eff;
	logic        steady;
	////////////////////////////////////////////////////////////////
	// settled mode and word, two cycles after reset
	always_ff @(posedge clk) begin
		up_reg <= srst ? 2'h0 : {up_reg[0], 1'b1};
		p1_reg <= {m, decimation_word};
		p2_reg <= p1_reg;
	end
	assign s = adc_status_flags;
	assign m = converter_mode_reg;
	assign eff = (!m[3] && decimation_word < 8'h0d) ? 8'h0d : decimation_word;
	assign steady = up_reg[1] && p1_reg == {m, decimation_word} && p2_reg == p1_reg;
	factor_scale_a: assert property (steady |-> decim_factor == {eff, 3'h0})
		else $error("decimation factor wrong");
	notch_gate_a: assert property (steady |-> notch_active == (m[6] && decimation_word >= 8'h44))
		else $error("notch gate wrong");
	burnout_gate_a: assert property (up_reg[1] |-> burnout_active == $past(burnout_enable
		&& buffer_select == `BUF_FULL && (channel_select == `CHAN_BURNOUT_A || channel_select == `CHAN_BURNOUT_B)))
		else $error("burnout gate wrong");
	restart_clears_a: assert property (mode_wr |=> filter_reset && !s[7] && !s[5] && !s[3])
		else $error("mode write did not restart");
	reserved_bits_a: assert property (s[6] == 1'b0 && s[2:0] == 3'h0)
		else $error("reserved status bits set");
	ref_flag_a: assert property (up_reg[1] && m[5] == $past(m[5]) |->
		s[4] == $past(m[5] && reference_select == `REF_PRIMARY && !ref_primary_ok))
		else $error("reference flag wrong");
	hold_results_a: assert property (s[7] && $past(s[7]) |-> $stable(result_data) && $stable(offset_coeff)
		&& $stable(gain_coeff) && $stable(s[5]) && $stable(s[3]))
		else $error("result changed while ready");
	clamp_ones_a: assert property ($rose(s[7]) && !s[5] && s[4] |-> result_data == 24'hffffff && s[3])
		else $error("missing reference result not clamped");
	cal_ready_a: assert property ($rose(s[5]) |-> s[7])
		else $error("calibration done without ready");
	cover property ($rose(s[7]) && s[5]);
	cover property ($rose(s[7]) && s[4]);
	cover property ($rose(notch_active));
endmodule
bind sigma_delta_adc_filter_status_ctrl adc_filter_monitor mon (.clk, .srst, .mode_wr, .reference_select,
	.buffer_select, .channel_select, .burnout_enable, .ref_primary_ok, .converter_mode_reg, .decimation_word,
	.decim_factor, .filter_reset, .notch_active, .burnout_active, .adc_status_flags, .result_data,
	.offset_coeff, .gain_coeff);
`default_nettype wire

// ---- verification/mod_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module mod_source (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    srst,
	// sample chosen by the bench
	input  wire adc_filter_pkg::sample_t level,
	input  wire logic                    sat,
	// filter side
	output var  logic                    mod_tick,
	output var  adc_filter_pkg::sample_t filt_data,
	output var  logic                    filt_sat
);
	import adc_filter_pkg::*;
	always_ff @(posedge clk) mod_tick <= srst ? 1'b0 : !mod_tick;
	assign filt_data = level;
	assign filt_sat = sat;
endmodule
`default_nettype wire

// ---- verification/sigma_delta_adc_filter_status_ctrl_bench.sv ----
`include "adc_filter_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module sigma_delta_adc_filter_status_ctrl_bench;
	import adc_filter_pkg::*;
	logic        clk = 0, srst = 1, sfr_wr = 0, sfr_rd = 0, mode_wr = 0, word_wr = 0, sat = 0;
	logic        burnout_enable = 0, ref_primary_ok = 1, filter_reset, notch_active, burnout_active;
	logic        mod_tick, filt_sat;
	logic [7:0]  sfr_addr = 0, sfr_wdata = 0, mode_wdata = 0, word_wdata = 0, rd;
	logic [7:0]  sfr_rdata, converter_mode_reg, decimation_word, adc_status_flags;
	logic [1:0]  reference_select = 0, buffer_select = 0;
	logic [3:0]  channel_select = 0;
	logic [10:0] decim_factor;
	sample_t     level = 24'h123456, filt_data, result_data, offset_coeff, gain_coeff;
	int          fail_count = 0, checked = 0, cycles = 0, waited = 0;
	sigma_delta_adc_filter_status_ctrl dut (.*);
	mod_source src (.*);
	////////////////////////////////////////////////////////////////
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fail_count++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk_ctl(string n, logic [10:0] e, logic [10:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk24(string n, sample_t e, sample_t g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic sfr(logic w, logic [7:0] a, logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = w;
		sfr_rd = !w;
		@(negedge clk);
		sfr_wr = 0;
		sfr_rd = 0;
		@(negedge clk);
		rd = sfr_rdata;
	endtask
	task automatic mode(logic [7:0] d);
		@(negedge clk);
		mode_wdata = d;
		mode_wr = 1;
		@(negedge clk);
		mode_wr = 0;
	endtask
	task automatic set_word(logic [7:0] d);
		@(negedge clk);
		word_wdata = d;
		word_wr = 1;
		@(negedge clk);
		word_wr = 0;
	endtask
	// counts falling edges until ready shows
	task automatic wait_ready();
		waited = 0;
		repeat (4000) if (adc_status_flags[7] !== 1'b1) begin
			@(negedge clk);
			waited++;
		end
	endtask
	task automatic conv(logic [7:0] m);
		mode(m);
		wait_ready();
	endtask
	initial begin
		repeat (5) @(negedge clk);
		srst = 0;
		sfr(0, 8'hd8, 8'h00);
		chk_ctl("status", `STATUS_RESET, rd);
		chk_ctl("word", `DECIM_RESET, decimation_word);
		chk_ctl("factor", 11'h228, decim_factor);
		sfr(0, 8'h10, 8'h00);
		chk_ctl("unmapped", 11'h000, rd);
		set_word(8'h04);
		conv(8'h2a);
		// 8 ticks per word unit, one tick per two clocks
		chk_ctl("conv time", 11'h040, 11'(waited));
		chk_ctl("factor", 11'h020, decim_factor);
		chk_ctl("status", 8'h80, adc_status_flags);
		chk_ctl("mode", 8'h28, converter_mode_reg);
		chk24("result", 24'h123456, result_data);
		sfr(1, 8'hd8, 8'hff);
		sfr(0, 8'hd8, 8'h00);
		chk_ctl("status read", 8'h80, rd);
		sfr(0, 8'h10, 8'h00);
		chk_ctl("unmapped", 11'h000, rd);
		level = 24'h00abcd;
		conv(8'h2b);
		level = 24'h111111;
		repeat (200) @(negedge clk);
		chk24("held", 24'h00abcd, result_data);
		sfr(1, 8'hd8, 8'h40);
		wait_ready();
		chk24("after clear", 24'h111111, result_data);
		set_word(8'h05);
		// first chop period ends near 624 clocks, the second near 1248
		mode(8'h22);
		repeat (900) @(negedge clk);
		level = 24'h333333;
		wait_ready();
		chk_ctl("factor", 11'h068, decim_factor);
		chk24("chop result", 24'h222222, result_data);
		reference_select = `REF_PRIMARY;
		ref_primary_ok = 0;
		conv(8'h2a);
		chk_ctl("status", 8'h98, adc_status_flags);
		chk24("clamped", 24'hffffff, result_data);
		reference_select = 2'h2;
		conv(8'h2a);
		chk_ctl("status", 8'h80, adc_status_flags);
		sat = 1;
		conv(8'h2a);
		chk_ctl("status", 8'h88, adc_status_flags);
		sat = 0;
		reference_select = `REF_PRIMARY;
		ref_primary_ok = 1;
		for (int i = 4; i < 8; i++) begin
			level = 24'(24'h000100 + i);
			conv(8'(8'h28 + i));
			chk24("coeff", level, i[0] ? gain_coeff : offset_coeff);
			chk_ctl("status", 8'ha0, adc_status_flags);
		end
		ref_primary_ok = 0;
		conv(8'h2d);
		chk24("gain kept", 24'h000107, gain_coeff);
		chk_ctl("status", 8'ha8, adc_status_flags & 8'ha8);
		ref_primary_ok = 1;
		set_word(8'h43);
		mode(8'h48);
		repeat (3) @(negedge clk);
		chk_ctl("notch", 11'h000, notch_active);
		set_word(8'h44);
		repeat (3) @(negedge clk);
		chk_ctl("notch", 11'h001, notch_active);
		burnout_enable = 1;
		for (int i = 0; i < 6; i++) begin
			channel_select = 4'(4'hc + i % 3);
			buffer_select = 2'(i / 3);
			repeat (2) @(negedge clk);
			chk_ctl("burnout", i < 2, burnout_active);
		end
		test_done();
	end
endmodule
`default_nettype wire
